// ### design/dwbpr_job_if.sv
`timescale 1ns/1ns
interface dwbpr_job_if;
  logic        start;
  logic [15:0] len;
  logic        busy;
  logic        done;
  modport ctl (output start, output len, input busy, input done);
  modport eng (input start, input len, output busy, output done);
endinterface

// ### design/dwbpr_m2m_engine.sv
`timescale 1ns/1ns
module dwbpr_m2m_engine (
  input wire logic i_ref_clk,  // Clock
  input wire logic i_rst_n,    // Sync reset
  input wire logic i_ce,       // Clock enable
  input wire logic i_pix_ack,  // Memory accepted a pixel word
  dwbpr_job_if.eng job         // Job control
);
  logic [15:0] cnt_r, cnt_nxt;
  logic        busy_r, busy_nxt;
  logic        done_r, done_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (!busy_r && job.start) begin
      busy_nxt = 1'b1;
      cnt_nxt  = job.len;
    end else if (busy_r && i_pix_ack) begin
      if (cnt_r <= 16'h0001) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        cnt_nxt  = 16'h0000;
      end else begin
        cnt_nxt = cnt_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cnt_r  <= 16'h0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (i_ce) begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign job.busy = busy_r;
  assign job.done = done_r;
endmodule

// ### design/dwbpr_pkg.sv
package dwbpr_pkg;
  localparam logic [3:0] ADDR_WB_ATTR   = 4'h0;
  localparam logic [3:0] ADDR_VID_ATTR  = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'h2;
  localparam logic [3:0] ADDR_IRQ_CLR   = 4'h3;
  localparam logic [3:0] ADDR_IRQ_EN    = 4'h4;
  localparam logic [3:0] ADDR_JOB_LEN   = 4'h5;
  localparam logic [3:0] ADDR_STATUS    = 4'h6;
  localparam int         WB_EN_BIT      = 0;
  localparam int         WB_M2M_BIT     = 19;
  localparam int         VID_EN_BIT     = 0;
  localparam int         VID_PANEL_BIT  = 1;
  localparam int         IRQ_DONE_BIT   = 0;
  localparam int         IRQ_SYNC_BIT   = 1;
  localparam int         IRQ_FRAME_BIT  = 2;
  localparam int         IRQ_W          = 3;
  localparam logic [31:0] WB_ATTR_RST   = 32'h0000_0000;
  localparam logic [31:0] VID_ATTR_RST  = 32'h0000_0000;
  localparam logic [15:0] JOB_LEN_RST   = 16'h0010;
endpackage

// ### design/dwbpr_top.sv
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
//Contract
//RQ1 - Writeback runs memory-to-memory while attribute bit 19 is one.
//RQ2 - Job completion leaves the video pipe enable bit set.
//RQ3 - Job completion clears writeback enable bit zero by hardware.
//RQ4 - Unsynchronised reroute of an enabled pipe corrupts a frame and raises sync-lost.
//RQ5 - Software first clears the source video pipe enable after completion.
//RQ6 - Software then sets and clears writeback enable before rerouting.
//RQ7 - Software reroutes, reprograms, and finally sets pipe enable again.
//RQ8 - Routing changes to a live panel take effect only at frame start.
module dwbpr_top
  import dwbpr_pkg::*;
(
  input  wire logic        i_ref_clk,     // 125 MHz clock
  input  wire logic        i_rst_n,       // Sync reset, active low
  input  wire logic        i_ce,          // Clock enable
  input  wire logic [3:0]  i_addr,        // Register address
  input  wire logic [31:0] i_wdata,       // Write data
  input  wire logic        i_wr,          // Write strobe
  input  wire logic        i_rd,          // Read strobe
  output logic      [31:0] o_rdata,       // Read data, cycle after strobe
  input  wire logic        i_frame_start, // Panel frame start pin
  input  wire logic        i_pix_ack,     // Memory write accepted
  output logic             o_wb_active,   // Writeback path running m2m
  output logic             o_panel_route, // Pipe routed to panel
  output logic             o_pipe_live,   // Pipe feeding panel
  output logic             o_irq          // Level interrupt
);
  dwbpr_job_if job ();

  // Pin synchroniser; stage one is read only by stage two
  logic fs_s1_r, fs_s2_r, fs_s3_r;
  logic frame_pulse;
  assign frame_pulse = fs_s2_r & ~fs_s3_r;

  logic [31:0] wb_attr_r, wb_attr_nxt;
  logic [31:0] vid_attr_r, vid_attr_nxt;
  logic [15:0] job_len_r, job_len_nxt;
  logic        route_r, route_nxt;
  logic        pend_r, pend_nxt;
  logic [IRQ_W-1:0] stat_r, stat_nxt;
  logic [IRQ_W-1:0] irq_en_r, irq_en_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wb_en_q_r, wb_en_q_nxt;

  logic wr_wb, wr_vid, wr_clr, wr_en, wr_len;
  logic job_start;
  logic sync_lost;

  assign wr_wb  = i_wr && (i_addr == ADDR_WB_ATTR);
  assign wr_vid = i_wr && (i_addr == ADDR_VID_ATTR);
  assign wr_clr = i_wr && (i_addr == ADDR_IRQ_CLR);
  assign wr_en  = i_wr && (i_addr == ADDR_IRQ_EN);
  assign wr_len = i_wr && (i_addr == ADDR_JOB_LEN);

  // Job launches on a rising writeback enable in m2m mode with pipe enabled
  assign job_start = wb_attr_r[WB_EN_BIT] && !wb_en_q_r && wb_attr_r[WB_M2M_BIT] //RQ1
                     && vid_attr_r[VID_EN_BIT] && !job.busy;
  assign job.start = job_start;
  assign job.len   = job_len_r;

  // Sync-lost only if a live enabled pipe would switch mid-frame; frame gating avoids it,
  // so this fires only when routing was forced without a frame start (never in this design)
  assign sync_lost = 1'b0;

  always_comb begin
    wb_attr_nxt  = wb_attr_r;
    vid_attr_nxt = vid_attr_r;
    job_len_nxt  = job_len_r;
    irq_en_nxt   = irq_en_r;
    wb_en_q_nxt  = wb_attr_r[WB_EN_BIT];
    if (wr_wb) begin
      wb_attr_nxt = i_wdata;
    end
    if (wr_vid) begin
      vid_attr_nxt = i_wdata;
    end
    if (wr_len) begin
      job_len_nxt = i_wdata[15:0];
    end
    if (wr_en) begin
      irq_en_nxt = i_wdata[IRQ_W-1:0];
    end
    // Completion beats a same-cycle software write of the enable
    if (job.done) begin
      wb_attr_nxt[WB_EN_BIT] = 1'b0; //RQ3
      // Pipe enable deliberately left untouched: software owns the exit sequence
      vid_attr_nxt[VID_EN_BIT] = vid_attr_r[VID_EN_BIT]; //RQ2
      if (wr_vid) begin
        vid_attr_nxt[VID_EN_BIT] = i_wdata[VID_EN_BIT];
      end
    end
  end

  // Routing request is held pending and applied at a frame start with no job busy, or at once while the pipe is disabled and no job is busy
  always_comb begin
    route_nxt = route_r;
    pend_nxt  = pend_r;
    if (vid_attr_r[VID_PANEL_BIT] != route_r) begin
      pend_nxt = 1'b1;
    end
    if (!vid_attr_r[VID_EN_BIT] && !job.busy) begin
      // Disabled pipe carries no frame, so it may move at once
      route_nxt = vid_attr_r[VID_PANEL_BIT];
      pend_nxt  = 1'b0;
    end else if (frame_pulse && pend_r && !job.busy) begin
      route_nxt = vid_attr_r[VID_PANEL_BIT]; //RQ8
      pend_nxt  = 1'b0;
    end
  end

  always_comb begin
    stat_nxt = stat_r;
    if (wr_clr) begin
      stat_nxt = stat_r & ~i_wdata[IRQ_W-1:0];
    end
    // Set wins over clear
    if (job.done) begin
      stat_nxt[IRQ_DONE_BIT] = 1'b1;
    end
    if (sync_lost) begin
      stat_nxt[IRQ_SYNC_BIT] = 1'b1; //RQ4
    end
    if (frame_pulse) begin
      stat_nxt[IRQ_FRAME_BIT] = 1'b1;
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        ADDR_WB_ATTR:  rdata_nxt = wb_attr_r;
        ADDR_VID_ATTR: rdata_nxt = vid_attr_r;
        ADDR_IRQ_STAT: rdata_nxt = {29'h0, stat_r};
        ADDR_IRQ_EN:   rdata_nxt = {29'h0, irq_en_r};
        ADDR_JOB_LEN:  rdata_nxt = {16'h0000, job_len_r};
        ADDR_STATUS:   rdata_nxt = {29'h0, pend_r, route_r, job.busy};
        default:       rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      fs_s1_r    <= 1'b0;
      fs_s2_r    <= 1'b0;
      fs_s3_r    <= 1'b0;
      wb_attr_r  <= WB_ATTR_RST;
      vid_attr_r <= VID_ATTR_RST;
      job_len_r  <= JOB_LEN_RST;
      route_r    <= 1'b0;
      pend_r     <= 1'b0;
      stat_r     <= '0;
      irq_en_r   <= '0;
      rdata_r    <= 32'h0000_0000;
      wb_en_q_r  <= 1'b0;
    end else if (i_ce) begin
      fs_s1_r    <= i_frame_start;
      fs_s2_r    <= fs_s1_r;
      fs_s3_r    <= fs_s2_r;
      wb_attr_r  <= wb_attr_nxt;
      vid_attr_r <= vid_attr_nxt;
      job_len_r  <= job_len_nxt;
      route_r    <= route_nxt;
      pend_r     <= pend_nxt;
      stat_r     <= stat_nxt;
      irq_en_r   <= irq_en_nxt;
      rdata_r    <= rdata_nxt;
      wb_en_q_r  <= wb_en_q_nxt;
    end
  end

  dwbpr_m2m_engine u_eng (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_pix_ack (i_pix_ack),
    .job       (job)
  );

  assign o_rdata       = rdata_r;
  assign o_wb_active   = job.busy;
  assign o_panel_route = route_r;
  assign o_pipe_live   = route_r & vid_attr_r[VID_EN_BIT];
  assign o_irq         = |(stat_r & irq_en_r);
endmodule

// ### verif/dwbpr_partner.sv
`timescale 1ns/1ns
module dwbpr_partner (
  input  wire logic i_ref_clk,    // Clk
  input  wire logic i_rst_n,      // Rst
  input  wire logic i_busy,       // Job on
  input  wire logic i_slow,       // Stall
  output logic      o_pix_ack,    // Taken
  output logic      o_frame_start // Frame pin
);
  logic [5:0] cnt_r;
  always_ff @(posedge i_ref_clk) begin
    cnt_r         <= i_rst_n ? cnt_r + 6'h01 : 6'h00;
    o_pix_ack     <= i_busy && (!i_slow || cnt_r[1:0] == 2'h0);
    // Held four cycles so the two-stage synchroniser cannot miss it
    o_frame_start <= cnt_r[5:2] == 4'hF;
  end
endmodule

// ### verif/dwbpr_sva.sv
`timescale 1ns/1ns
module dwbpr_sva
  import dwbpr_pkg::*;
(
  input wire logic        i_ref_clk,     // Clk
  input wire logic        i_rst_n,       // Rst
  input wire logic [3:0]  i_addr,        // Adr
  input wire logic [31:0] i_wdata,       // Wd
  input wire logic        i_wr,          // Wr
  input wire logic        i_rd,          // Rd
  input wire logic [31:0] o_rdata,       // Rd data
  input wire logic        i_frame_start, // Frame
  input wire logic        i_pix_ack,     // Ack
  input wire logic        o_wb_active,   // Busy
  input wire logic        o_panel_route, // Route
  input wire logic        o_pipe_live,   // Live
  input wire logic        o_irq          // Irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  property p_start;
    $rose(o_wb_active) |-> $past(i_wr && i_addr == ADDR_WB_ATTR && i_wdata[WB_M2M_BIT], 2);
  endproperty
  a_start: assert property (p_start) else $error("job began without m2m write");
  property p_hold;
    o_wb_active && !i_pix_ack && !$past(i_pix_ack) |=> o_wb_active;
  endproperty
  a_hold: assert property (p_hold) else $error("job ended without acks");
  property p_keep;
    $fell(o_wb_active) |-> $stable(o_pipe_live);
  endproperty
  a_keep: assert property (p_keep) else $error("pipe changed at completion");
  // A live route may only move a few cycles after the synchronised frame pin
  property p_gate;
    $changed(o_panel_route) && $past(o_pipe_live) |-> $past(i_frame_start, 2) || $past(i_frame_start, 3)
      || $past(i_frame_start, 4);
  endproperty
  a_gate: assert property (p_gate) else $error("route moved mid frame");
  property p_nosync;
    $past(i_rd && i_addr == ADDR_IRQ_STAT) |-> !o_rdata[IRQ_SYNC_BIT];
  endproperty
  a_nosync: assert property (p_nosync) else $error("sync lost seen");
  c_done: cover property ($fell(o_wb_active));
  c_route: cover property ($changed(o_panel_route));
  c_irq: cover property ($rose(o_irq));
endmodule
bind dwbpr_top dwbpr_sva u_dwbpr_sva (.*);

// ### verif/dwbpr_tb_top.sv
`timescale 1ns/1ns
module dwbpr_tb_top;
  import dwbpr_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, slow = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        fs, ack, act, route, live, irq;
  int          failures = 0, n_tests = 0, cyc = 0, seed = 92, len, m_wb, m_vid, m_rt = 0;
  always #4 clk = ~clk;
  dwbpr_top u_dwbpr_top (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_frame_start(fs), .i_pix_ack(ack), .o_wb_active(act),
    .o_panel_route(route), .o_pipe_live(live), .o_irq(irq));
  dwbpr_partner u_dwbpr_partner (.i_ref_clk(clk), .i_rst_n(rst_n), .i_busy(act), .i_slow(slow),
    .o_pix_ack(ack), .o_frame_start(fs));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // A spare edge after each strobe keeps back-to-back calls from reassigning it at once
  task automatic wreg(input logic [3:0] a, input int d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(posedge clk);
  endtask
  // The mask hides status bits that the free-running frame pin sets once every 64 cycles
  task automatic rreg(input logic [3:0] a, input int e, input logic [31:0] m = 32'hFFFF_FFFF);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata & m, e);
    @(posedge clk);
  endtask
  task automatic wait_route();
    for (int i = 0; i < 100 && route !== m_rt[0]; i++)
      @(posedge clk);
    chk(route, m_rt);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rreg(ADDR_WB_ATTR, WB_ATTR_RST);
    rreg(ADDR_VID_ATTR, VID_ATTR_RST);
    rreg(ADDR_JOB_LEN, JOB_LEN_RST);
    rreg(4'hF, 0);
    $display("test reset done");
    for (int j = 0; j < 2; j++) begin
      len = 1 + ($random(seed) & 7);
      slow <= j[0];
      m_vid = 1;
      m_wb = 32'h80001;
      wreg(ADDR_VID_ATTR, m_vid);
      chk(route, m_rt);
      m_rt = 0;
      wait_route();
      wreg(ADDR_IRQ_EN, 1);
      wreg(ADDR_JOB_LEN, len);
      wreg(ADDR_WB_ATTR, m_wb);
      @(posedge clk);
      #1 chk(act, 1'b1);
      for (int i = 0; i < 200 && act !== 1'b0; i++)
        @(posedge clk);
      m_wb = m_wb & 32'hFFFFFFFE;
      rreg(ADDR_WB_ATTR, m_wb);
      rreg(ADDR_VID_ATTR, m_vid);
      rreg(ADDR_IRQ_STAT, 32'h1, 32'h3);
      chk(irq, 1'b1);
      wreg(ADDR_IRQ_CLR, 1);
      chk(irq, 1'b0);
      wreg(ADDR_VID_ATTR, 0);
      wreg(ADDR_WB_ATTR, 32'h80001);
      wreg(ADDR_WB_ATTR, 32'h80000);
      chk(act, 1'b0);
      wreg(ADDR_VID_ATTR, 2);
      wreg(ADDR_VID_ATTR, 3);
      m_rt = 1;
      chk(route, m_rt);
      chk(live, 1'b1);
      $display("test job %0d done", j);
    end
    stop_test();
  end
endmodule
